// ===== rtl/amsc_pkg.sv
// package of constants for the converter mode and realignment control
package amsc_pkg;
    localparam logic [1:0] MODE_HIGH_SPEED = 2'h0;
    localparam logic [1:0] MODE_HIGH_RES = 2'h1;
    localparam logic [1:0] MODE_LOW_POWER = 2'h2;
    localparam logic [1:0] MODE_LOW_SPEED = 2'h3;
    localparam logic [2:0] FMT_SPI_FIRST = 3'h0;
    localparam logic [2:0] FMT_SPI_LAST = 3'h2;
    localparam logic [2:0] FMT_FS_FIRST = 3'h3;
    localparam logic [2:0] FMT_FS_LAST = 3'h5;
    localparam logic [2:0] FMT_MODULATOR = 3'h6;
    localparam int RATIO_W = 12;
    localparam logic [11:0] RATIO_256 = 12'h100;
    localparam logic [11:0] RATIO_512 = 12'h200;
    localparam logic [11:0] RATIO_2560 = 12'hA00;
    localparam int SETTLE_W = 8;
    localparam logic [7:0] SETTLE_SPI_CONV = 8'h81;
    localparam logic [7:0] SETTLE_FS_CONV = 8'h80;
    typedef enum logic [1:0] {
        AMSC_HALT = 2'b00,
        AMSC_SETTLE = 2'b01,
        AMSC_RUN = 2'b11
    } amsc_state_e;
endpackage : amsc_pkg

// ===== rtl/amsc_conv_if.sv
// interface carrying conversion-period control between top and rate counter
`timescale 1ns/1ps
interface amsc_conv_if;
    logic run;
    logic [11:0] ratio;
    logic conv_tick;
    modport ctrl (output run, output ratio, input conv_tick);
    modport rate (input run, input ratio, output conv_tick);
endinterface : amsc_conv_if

// ===== rtl/amsc_rate_counter.sv
// conversion period counter, one tick per output word
`timescale 1ns/1ps
module amsc_rate_counter (
    input wire logic i_clock,
    input wire logic i_reset,
    amsc_conv_if.rate conv
);
    logic [amsc_pkg::RATIO_W-1:0] count_q;
    logic tick_q;
    wire last_w = (count_q >= conv.ratio - 12'h001);
    always_ff @(posedge i_clock) begin
        // cleared while halted so restart aligns to one clock edge; see R10 see R12
        if (i_reset || !conv.run) begin
            count_q <= '0;
            tick_q <= 1'b0;
        end else begin
            count_q <= last_w ? '0 : count_q + 12'h001; // see R3 see R6
            tick_q <= last_w;
        end
    end
    assign conv.conv_tick = tick_q;
endmodule : amsc_rate_counter

// ===== rtl/amsc_control.sv
// mode decode, realignment and settling control for eight-channel converter
`timescale 1ns/1ps
// Summary of operation
// R1 - mode pins: 00 fast, 01 fine, 10 lowpower, 11 slow
// R2 - mode pins watched continuously, no reset needed
// R3 - ratio 256 fast, 512 fine with divide high
// R4 - low power ratio 512 divide high, 256 low
// R5 - low speed ratio 2560 divide high, 512 low
// R6 - data rate follows master clock rate
// R7 - spi: ready held high until settled, 129 max
// R8 - frame mode: data low until settled, 127-128
// R9 - host treats first one bit as valid
// R10 - realign low stops, clears counters; high restarts
// R11 - all channels share clock and realign
// R12 - restart aligned to one master clock cycle
// R13 - spi: ready high at realign, low when valid
// R14 - frame mode: data low at realign, then valid
// R15 - host keeps clocks running before realign release
// R16 - host realigns after any clock interruption
// R17 - host realigns once after power-on
// R18 - format pins pick spi, frame, modulator
// R19 - ready falls on new word, rises on bit clock
module amsc_control (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [1:0] i_mode_select,
    input wire logic i_clock_divide_select,
    input wire logic [2:0] i_format_select,
    input wire logic i_realign_n,
    input wire logic i_bit_clock,
    output logic o_sample_ready_n,
    output logic o_data_valid,
    output logic o_data_force_low,
    output logic o_frame_protocol,
    output logic o_modulator_mode,
    output logic o_converting,
    output logic o_word_strobe,
    output logic [1:0] o_mode_active
);
    // three-stage sync on pins; a change counts when stages two and three agree
    logic [1:0] mode_s1_q, mode_s2_q, mode_s3_q, mode_q;
    logic [2:0] fmt_s1_q, fmt_s2_q, fmt_s3_q, fmt_q;
    logic div_s1_q, div_s2_q, div_s3_q, div_q;
    logic rl_s1_q, rl_s2_q, rl_s3_q, rl_q;
    logic bc_s1_q, bc_s2_q, bc_s3_q, bc_q;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
            mode_s3_q <= 2'h0;
            fmt_s1_q <= 3'h0;
            fmt_s2_q <= 3'h0;
            fmt_s3_q <= 3'h0;
            div_s1_q <= 1'b1;
            div_s2_q <= 1'b1;
            div_s3_q <= 1'b1;
            rl_s1_q <= 1'b0;
            rl_s2_q <= 1'b0;
            rl_s3_q <= 1'b0;
            bc_s1_q <= 1'b0;
            bc_s2_q <= 1'b0;
            bc_s3_q <= 1'b0;
        end else begin
            mode_s1_q <= i_mode_select;
            mode_s2_q <= mode_s1_q;
            mode_s3_q <= mode_s2_q;
            fmt_s1_q <= i_format_select;
            fmt_s2_q <= fmt_s1_q;
            fmt_s3_q <= fmt_s2_q;
            div_s1_q <= i_clock_divide_select;
            div_s2_q <= div_s1_q;
            div_s3_q <= div_s2_q;
            rl_s1_q <= i_realign_n;
            rl_s2_q <= rl_s1_q;
            rl_s3_q <= rl_s2_q;
            bc_s1_q <= i_bit_clock;
            bc_s2_q <= bc_s1_q;
            bc_s3_q <= bc_s2_q;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mode_q <= amsc_pkg::MODE_HIGH_SPEED;
            fmt_q <= amsc_pkg::FMT_SPI_FIRST;
            div_q <= 1'b1;
            rl_q <= 1'b0;
            bc_q <= 1'b0;
        end else begin
            if (mode_s2_q == mode_s3_q) mode_q <= mode_s3_q; // see R2
            if (fmt_s2_q == fmt_s3_q) fmt_q <= fmt_s3_q;
            if (div_s2_q == div_s3_q) div_q <= div_s3_q;
            if (rl_s2_q == rl_s3_q) rl_q <= rl_s3_q;
            if (bc_s2_q == bc_s3_q) bc_q <= bc_s3_q;
        end
    end

    function automatic logic [11:0] ratio_of(input logic [1:0] mode, input logic div);
        case (mode)
            amsc_pkg::MODE_HIGH_SPEED: ratio_of = amsc_pkg::RATIO_256; // see R1 see R3
            amsc_pkg::MODE_HIGH_RES: ratio_of = amsc_pkg::RATIO_512; // see R3
            amsc_pkg::MODE_LOW_POWER:
                ratio_of = div ? amsc_pkg::RATIO_512 : amsc_pkg::RATIO_256; // see R4
            amsc_pkg::MODE_LOW_SPEED:
                ratio_of = div ? amsc_pkg::RATIO_2560 : amsc_pkg::RATIO_512; // see R5
            default: ratio_of = amsc_pkg::RATIO_256;
        endcase
    endfunction : ratio_of

    // format decode; reserved code 111 treated as spi
    wire frame_w = (fmt_q >= amsc_pkg::FMT_FS_FIRST) && (fmt_q <= amsc_pkg::FMT_FS_LAST); // see R18
    wire modulator_w = (fmt_q == amsc_pkg::FMT_MODULATOR); // see R18
    wire [amsc_pkg::SETTLE_W-1:0] settle_target_w =
        frame_w ? amsc_pkg::SETTLE_FS_CONV : amsc_pkg::SETTLE_SPI_CONV; // see R7 see R8
    logic bc_prev_q;
    logic [1:0] mode_prev_q;
    wire bc_fall_w = bc_prev_q && !bc_q;
    wire mode_change_w = (mode_q != mode_prev_q);

    // one rate counter serves all eight channels, so they always sample together; see R11
    amsc_conv_if conv ();
    amsc_rate_counter u_rate (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .conv(conv)
    );
    assign conv.run = rl_q; // see R10 see R11
    assign conv.ratio = ratio_of(mode_q, div_q); // see R3 see R4 see R5
    wire tick_w = conv.conv_tick;

    amsc_pkg::amsc_state_e state_q;
    amsc_pkg::amsc_state_e state_d;
    logic [amsc_pkg::SETTLE_W-1:0] settle_q;
    logic [amsc_pkg::SETTLE_W-1:0] settle_d;
    wire settle_done_w = (settle_q == settle_target_w - 8'h01); // see R7 see R8

    // settling restarts from zero on realign release or on a new mode
    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        case (state_q)
            amsc_pkg::AMSC_HALT: begin
                // rate counter is already cleared while halted; settle count is cleared here on release; see R10
                if (rl_q) begin
                    state_d = amsc_pkg::AMSC_SETTLE;
                    settle_d = '0;
                end
            end
            amsc_pkg::AMSC_SETTLE: begin
                if (!rl_q) begin
                    state_d = amsc_pkg::AMSC_HALT; // see R10
                end else if (mode_change_w) begin
                    settle_d = '0; // see R2 see R7 see R8
                end else if (tick_w && settle_done_w) begin
                    state_d = amsc_pkg::AMSC_RUN;
                end else if (tick_w) begin
                    settle_d = settle_q + 8'h01;
                end
            end
            amsc_pkg::AMSC_RUN: begin
                if (!rl_q) begin
                    state_d = amsc_pkg::AMSC_HALT; // see R13 see R14
                end else if (mode_change_w) begin
                    state_d = amsc_pkg::AMSC_SETTLE; // see R2 see R7 see R8
                    settle_d = '0;
                end
            end
            default: begin
                state_d = amsc_pkg::AMSC_HALT;
            end
        endcase
    end

    logic sample_ready_n_q;
    logic data_valid_q;
    logic data_force_low_q;
    logic frame_q;
    logic modulator_q;
    logic converting_q;
    logic word_strobe_q;
    logic [1:0] mode_active_q;
    wire run_d_w = (state_d == amsc_pkg::AMSC_RUN);
    // a new word beats a bit-clock fall in the same cycle, so no word goes unflagged
    wire sample_ready_n_d =
        !run_d_w ? 1'b1 : (tick_w ? 1'b0 : (bc_fall_w ? 1'b1 : sample_ready_n_q)); // see R13 see R19

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q <= amsc_pkg::AMSC_HALT;
            settle_q <= '0;
            bc_prev_q <= 1'b0;
            mode_prev_q <= amsc_pkg::MODE_HIGH_SPEED;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
            bc_prev_q <= bc_q;
            mode_prev_q <= mode_q;
        end
    end

    // every pin straight from a flip-flop; costs one cycle of latency
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sample_ready_n_q <= 1'b1;
            data_valid_q <= 1'b0;
            data_force_low_q <= 1'b1;
            frame_q <= 1'b0;
            modulator_q <= 1'b0;
            converting_q <= 1'b0;
            word_strobe_q <= 1'b0;
            mode_active_q <= amsc_pkg::MODE_HIGH_SPEED;
        end else begin
            sample_ready_n_q <= sample_ready_n_d; // see R7 see R13
            data_valid_q <= run_d_w;
            data_force_low_q <= !run_d_w; // see R8 see R14
            frame_q <= frame_w; // see R18
            modulator_q <= modulator_w; // see R18
            converting_q <= rl_q; // see R10
            word_strobe_q <= tick_w; // see R3
            mode_active_q <= mode_q; // see R1
        end
    end

    assign o_sample_ready_n = sample_ready_n_q;
    assign o_data_valid = data_valid_q;
    assign o_data_force_low = data_force_low_q;
    assign o_frame_protocol = frame_q;
    assign o_modulator_mode = modulator_q;
    assign o_converting = converting_q;
    assign o_word_strobe = word_strobe_q;
    assign o_mode_active = mode_active_q;
endmodule : amsc_control

// ===== tb/amsc_monitor.sv
// port checks for the mode and realignment control
`timescale 1ns/1ps
module amsc_monitor (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [1:0] i_mode_select,
    input wire logic [2:0] i_format_select,
    input wire logic i_realign_n,
    input wire logic o_sample_ready_n,
    input wire logic o_data_force_low,
    input wire logic o_frame_protocol,
    input wire logic o_modulator_mode,
    input wire logic o_converting,
    input wire logic o_word_strobe,
    input wire logic [1:0] o_mode_active
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence fmt_steady; $stable(i_format_select)[*7]; endsequence
    sequence sync_low; !i_realign_n[*7]; endsequence
    frame_pick_a: assert property (fmt_steady |->
        o_frame_protocol == (i_format_select inside {[3:5]})) else $error("frame decode");
    mod_pick_a: assert property (fmt_steady |->
        o_modulator_mode == (i_format_select == 3'h6)) else $error("modulator decode");
    mode_track_a: assert property ($stable(i_mode_select)[*7] |->
        o_mode_active == i_mode_select) else $error("mode decode");
    halt_stop_a: assert property (sync_low |-> !o_converting)
        else $error("still converting");
    no_word_a: assert property (sync_low |-> !o_word_strobe)
        else $error("word while halted");
    ready_hold_a: assert property (sync_low ##0 !o_frame_protocol |-> o_sample_ready_n)
        else $error("ready low in realign");
    data_low_a: assert property (sync_low ##0 o_frame_protocol |-> o_data_force_low)
        else $error("data not forced low");
    word_gap_a: assert property (o_word_strobe |=> !o_word_strobe[*8])
        else $error("words too close");
endmodule : amsc_monitor
bind amsc_control amsc_monitor MON (.*);

// ===== tb/amsc_host.sv
// host model driving the bit clock
`timescale 1ns/1ps
module amsc_host (
    input wire logic i_clock,
    input wire logic i_ready_n,
    input wire logic i_frame,
    output logic o_bit_clock
);
    int left = 0;
    logic [2:0] phase = 3'h0;
    initial o_bit_clock = 1'h0;
    // slow enough that the three-stage sync sees each level settle
    always @(posedge i_clock) begin
        phase <= phase + 3'h1;
        left <= !i_ready_n ? 16 : left - (left > 0);
        o_bit_clock <= (i_frame || left > 0) ? phase[2] : 1'h0;
    end
endmodule : amsc_host

// ===== tb/test_amsc_control.sv
// bench for the mode and realignment control
`timescale 1ns/1ps
module test_amsc_control;
    logic i_clock = 1'h0, i_reset = 1'h1, i_clock_divide_select = 1'h1, i_realign_n = 1'h1;
    logic [1:0] i_mode_select = 2'h0;
    logic [2:0] i_format_select = 3'h0;
    logic i_bit_clock, o_sample_ready_n, o_data_valid, o_data_force_low, o_frame_protocol;
    logic o_modulator_mode, o_converting, o_word_strobe;
    logic [1:0] o_mode_active;
    int num_errors = 0, tests_run = 0, n, k;
    always #50 i_clock = ~i_clock;
    amsc_control DUT (.*);
    amsc_host HOST (.i_clock, .i_ready_n(o_sample_ready_n), .i_frame(o_frame_protocol),
        .o_bit_clock(i_bit_clock));
    function automatic int ratio(int m, int d);
        int q[$] = '{256, 512, d ? 512 : 256, d ? 2560 : 512};
        return q[m];
    endfunction : ratio
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // cycles to the next word; capped so a dead counter cannot hang
    task automatic gap(output int c);
        c = 1;
        @(negedge i_clock);
        while (o_word_strobe !== 1'h1 && c < 3000) begin
            @(negedge i_clock);
            c++;
        end
    endtask : gap
    task automatic tally_and_finish;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #12000000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        n = $urandom(88);
        repeat (10) @(posedge i_clock);
        i_reset <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clock);
            i_mode_select <= 2'(i);
            i_clock_divide_select <= !i[2];
            repeat (3) gap(n);
            if (i < 4 || i % 4 > 1) chk(n, ratio(i % 4, i < 4));
            chk(o_mode_active, i % 4);
        end
        repeat (2) begin
            @(posedge i_clock);
            i_mode_select <= 2'h0;
            i_clock_divide_select <= 1'h1;
            i_format_select <= 3'($urandom % 6);
            i_realign_n <= 1'h0;
            repeat (8 + $urandom % 4) @(negedge i_clock);
            chk(o_converting, 0);
            chk(o_frame_protocol ? o_data_force_low : o_sample_ready_n, 1);
            @(posedge i_clock);
            i_realign_n <= 1'h1;
            k = 0;
            while (o_data_valid !== 1'h1 && k < 140) begin
                gap(n);
                k++;
            end
            chk(o_frame_protocol ? k inside {[127:128]} : k <= 129, 1);
        end
        tally_and_finish;
    end
endmodule : test_amsc_control
